/* hdl/pmtr_pkg.sv */
// Package of widths, reset values, states and framing constants for the program memory reader.
package pmtr_pkg;

	// Program store shape: 4K words of 16 bits.
	localparam int PM_AW = 12;
	localparam int PM_DW = 16;
	localparam int PM_DEPTH = 4096;

	// Byte and page widths.
	localparam int BYTE_W = 8;
	localparam int PAGE_W = 4;
	localparam int SECTOR_W = 3;

	// Program counter reset vector and page of the last-page table reads.
	localparam logic [PM_AW-1:0] RESET_VECTOR = 12'h000;
	localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hF;
	localparam logic [PM_AW-1:0] PC_STEP = 12'h001;

	// Implemented bits of the table-high latch; unimplemented bits read as zero.
	localparam logic [BYTE_W-1:0] TABLE_HIGH_LATCH_IMPL_MASK = 8'hFF;
	localparam logic [BYTE_W-1:0] TABLE_HIGH_LATCH_RESET = 8'h00;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [PM_DW-1:0] WORD_RESET = 16'h0000;

	// Sector of the destination register for the normal table reads.
	localparam logic [SECTOR_W-1:0] SECTOR_0 = 3'h0;

	// One instruction cycle is four system clocks, phases T1 to T4.
	localparam logic [1:0] PH_T1 = 2'h0;
	localparam logic [1:0] PH_T2 = 2'h1;
	localparam logic [1:0] PH_T4 = 2'h3;

	// Serial programming frame: command bit, 12 address bits, 16 data bits.
	localparam logic [4:0] ICP_ADDR_LAST = 5'h0C;
	localparam logic [4:0] ICP_FRAME_LAST = 5'h1C;
	localparam logic [4:0] ICP_CNT_RESET = 5'h00;
	localparam logic [4:0] ICP_CNT_STEP = 5'h01;

	// Sequencer states.
	typedef enum logic [1:0] {
		PMTR_ST_FETCH = 2'b00,
		PMTR_ST_TABLE = 2'b01,
		PMTR_ST_PROG = 2'b10
	} pmtr_state_t;

endpackage

/* hdl/pmtr_prog_store.sv */
// Single-port 4K x 16 program store with synchronous read and write.
module pmtr_prog_store (
	input wire logic i_clk,
	input wire logic [pmtr_pkg::PM_AW-1:0] i_addr,
	input wire logic i_rd_en,
	input wire logic i_wr_en,
	input wire logic [pmtr_pkg::PM_DW-1:0] i_wdata,
	output logic [pmtr_pkg::PM_DW-1:0] o_rdata
);

	// Storage array; contents are undefined until programmed.
	logic [pmtr_pkg::PM_DW-1:0] mem [0:pmtr_pkg::PM_DEPTH-1];

	// Write takes the port; a read returns the word one clock later.
	always_ff @(posedge i_clk) begin
		if (i_wr_en) begin
			mem[i_addr] <= i_wdata;
		end else if (i_rd_en) begin
			o_rdata <= mem[i_addr];
		end
	end

endmodule

/* hdl/pmtr_reader.sv */
// Program counter, instruction fetch, table read path and serial programming port.
//
// Summary of operation
// - A program store of 4K words of 16 bits holds code and tables and is addressed by the PC.
// - Any reset loads the PC with 0000H and fetching starts there.
// - The table address is the pointer high byte, or page FH for last-page reads, joined to the pointer low byte, apart from the PC.
// - A table read fetches the word at the table address and writes its low byte to the operand.
// - A table read places the high byte of the fetched word in the table-high latch.
// - Bits of the high byte that the word does not implement arrive as zero in the latch.
// - Normal table reads target sector 0 while extended table reads target any sector, sector 0 included.
// - Every table read, normal or extended, takes exactly two instruction cycles.
// - Instructions can both read and write the table-high latch.
// - Programming moves serial address in and data both ways on one line, clocked by the programmer.
// - The PC is 12 bits and a write to its low byte jumps within the current 256-word page.
module pmtr_reader (
	input wire logic i_clk,
	input wire logic i_rst_b,
	output logic o_cyc_stb,
	output logic [pmtr_pkg::PM_DW-1:0] o_instr,
	output logic o_instr_valid,
	output logic [pmtr_pkg::PM_AW-1:0] o_pc,
	input wire logic i_jump,
	input wire logic [pmtr_pkg::PM_AW-1:0] i_jump_addr,
	input wire logic i_pc_low_byte_wr,
	input wire logic [pmtr_pkg::BYTE_W-1:0] i_pc_low_byte_wdata,
	output logic [pmtr_pkg::BYTE_W-1:0] o_pc_low_byte,
	input wire logic i_tblp_wr,
	input wire logic i_tbhp_wr,
	input wire logic [pmtr_pkg::BYTE_W-1:0] i_ptr_wdata,
	output logic [pmtr_pkg::BYTE_W-1:0] o_tblp,
	output logic [pmtr_pkg::PAGE_W-1:0] o_tbhp,
	input wire logic i_table_read_op,
	input wire logic i_table_read_last_op,
	input wire logic i_ext_table_read_op,
	input wire logic i_ext_table_read_last_op,
	input wire logic [pmtr_pkg::SECTOR_W-1:0] i_dest_sector,
	input wire logic [pmtr_pkg::BYTE_W-1:0] i_dest_addr,
	output logic o_dm_wr,
	output logic [pmtr_pkg::SECTOR_W-1:0] o_dm_sector,
	output logic [pmtr_pkg::BYTE_W-1:0] o_dm_addr,
	output logic [pmtr_pkg::BYTE_W-1:0] o_dm_wdata,
	input wire logic i_table_high_latch_wr,
	input wire logic [pmtr_pkg::BYTE_W-1:0] i_table_high_latch_wdata,
	output logic [pmtr_pkg::BYTE_W-1:0] o_table_high_latch,
	input wire logic i_prog_en,
	output logic o_cpu_hold,
	input wire logic i_prog_serial_clock,
	input wire logic i_prog_serial_io,
	output logic o_prog_serial_io,
	output logic o_prog_serial_io_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	pmtr_pkg::pmtr_state_t state_ff;
	pmtr_pkg::pmtr_state_t nxt_state;
	logic [1:0] phase_ff;
	logic [pmtr_pkg::PM_AW-1:0] pc_ff;
	logic [pmtr_pkg::PM_DW-1:0] instr_ff;
	logic instr_valid_ff;
	logic [pmtr_pkg::BYTE_W-1:0] tblp_ff;
	logic [pmtr_pkg::PAGE_W-1:0] tbhp_ff;
	logic [pmtr_pkg::PM_AW-1:0] tab_addr_ff;
	logic [pmtr_pkg::SECTOR_W-1:0] dest_sector_ff;
	logic [pmtr_pkg::BYTE_W-1:0] dest_addr_ff;
	logic [pmtr_pkg::BYTE_W-1:0] table_high_latch_ff;
	logic dm_wr_ff;
	logic [pmtr_pkg::BYTE_W-1:0] dm_wdata_ff;
	logic tab_req;
	logic tab_last;
	logic [pmtr_pkg::PM_AW-1:0] mem_addr;
	logic mem_rd_en;
	logic mem_wr_en;
	logic [pmtr_pkg::PM_DW-1:0] mem_rdata;
	logic [2:0] sck_sync_ff;
	logic [2:0] sio_sync_ff;
	logic sck_flt_ff;
	logic sio_flt_ff;
	logic sck_rise;
	logic [4:0] icp_cnt_ff;
	logic icp_read_ff;
	logic [pmtr_pkg::PM_AW-1:0] icp_addr_ff;
	logic [pmtr_pkg::PM_DW-1:0] icp_data_ff;
	logic icp_rd_req_ff;
	logic icp_rd_cap_ff;
	logic icp_wr_ff;
	logic icp_oe_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Instruction cycle timing and sequencing.

	// Chooses the page for last-page reads, else the pointer high byte.
	function automatic logic [pmtr_pkg::PM_AW-1:0] table_addr(
		input logic last,
		input logic [pmtr_pkg::PAGE_W-1:0] hi,
		input logic [pmtr_pkg::BYTE_W-1:0] lo
	);
		table_addr = last ? {pmtr_pkg::LAST_PAGE, lo} : {hi, lo};
	endfunction

	// Any form of table read requested by the core this cycle.
	assign tab_req = i_table_read_op | i_table_read_last_op | i_ext_table_read_op
		| i_ext_table_read_last_op;
	assign tab_last = i_table_read_last_op | i_ext_table_read_last_op;

	// The phase counter splits each instruction cycle into four clocks.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			phase_ff <= pmtr_pkg::PH_T1;
		end else begin
			phase_ff <= phase_ff + 2'h1;
		end
	end

	// Last clock of an instruction cycle; requests are taken here.
	assign o_cyc_stb = (phase_ff == pmtr_pkg::PH_T4);

	// Next state at the cycle boundary: programming, the table cycle, or a normal fetch.
	always_comb begin
		nxt_state = state_ff;
		if (o_cyc_stb) begin
			if (i_prog_en) begin
				nxt_state = pmtr_pkg::PMTR_ST_PROG;
			end else if (state_ff == pmtr_pkg::PMTR_ST_FETCH && tab_req && !i_jump) begin
				nxt_state = pmtr_pkg::PMTR_ST_TABLE;
			end else begin
				nxt_state = pmtr_pkg::PMTR_ST_FETCH;
			end
		end
	end

	// Sequencer state register; reset starts with a fetch.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_ff <= pmtr_pkg::PMTR_ST_FETCH;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Program counter.

	// The PC steps after each fetch without a table request, jumps on request, and holds while a table word is read.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pc_ff <= pmtr_pkg::RESET_VECTOR;
		end else if (o_cyc_stb && state_ff != pmtr_pkg::PMTR_ST_PROG) begin
			if (i_jump) begin
				pc_ff <= i_jump_addr;
			end else if (i_pc_low_byte_wr) begin
				pc_ff <= {pc_ff[pmtr_pkg::PM_AW-1:pmtr_pkg::BYTE_W], i_pc_low_byte_wdata};
			end else if (state_ff == pmtr_pkg::PMTR_ST_FETCH && !tab_req) begin
				pc_ff <= pc_ff + pmtr_pkg::PC_STEP;
			end
		end
	end

	assign o_pc = pc_ff;
	assign o_pc_low_byte = pc_ff[pmtr_pkg::BYTE_W-1:0];

	////////////////////////////////////////////////////////////////////////////////
	// Program store port.

	// The port serves the PC, the table address in the table cycle, or the programmer.
	always_comb begin
		case (state_ff)
			pmtr_pkg::PMTR_ST_FETCH: begin
				mem_addr = pc_ff;
			end
			pmtr_pkg::PMTR_ST_TABLE: begin
				mem_addr = tab_addr_ff;
			end
			pmtr_pkg::PMTR_ST_PROG: begin
				mem_addr = icp_addr_ff;
			end
			default: begin
				mem_addr = pc_ff;
			end
		endcase
	end

	assign mem_rd_en = (state_ff == pmtr_pkg::PMTR_ST_PROG) ? icp_rd_req_ff
		: (phase_ff == pmtr_pkg::PH_T1);
	assign mem_wr_en = (state_ff == pmtr_pkg::PMTR_ST_PROG) && icp_wr_ff;

	// Single 4K x 16 store.
	pmtr_prog_store u_store (
		.i_clk(i_clk),
		.i_addr(mem_addr),
		.i_rd_en(mem_rd_en),
		.i_wr_en(mem_wr_en),
		.i_wdata(icp_data_ff),
		.o_rdata(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Instruction word.

	// A fetched word is captured at T2 and presented from T3; the table cycle brings no new instruction.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			instr_ff <= pmtr_pkg::WORD_RESET;
			instr_valid_ff <= 1'b0;
		end else if (phase_ff == pmtr_pkg::PH_T2) begin
			if (state_ff == pmtr_pkg::PMTR_ST_FETCH) begin
				instr_ff <= mem_rdata;
				instr_valid_ff <= 1'b1;
			end else begin
				instr_valid_ff <= 1'b0;
			end
		end
	end

	assign o_instr = instr_ff;
	assign o_instr_valid = instr_valid_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Table pointer and table request.

	// Pointer bytes written by instructions.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tblp_ff <= pmtr_pkg::BYTE_RESET;
			tbhp_ff <= pmtr_pkg::LAST_PAGE & 4'h0;
		end else if (o_cyc_stb) begin
			if (i_tblp_wr) begin
				tblp_ff <= i_ptr_wdata;
			end
			if (i_tbhp_wr) begin
				tbhp_ff <= i_ptr_wdata[pmtr_pkg::PAGE_W-1:0];
			end
		end
	end

	assign o_tblp = tblp_ff;
	assign o_tbhp = tbhp_ff;

	// The table address and destination are captured as the table request is taken at the end of the fetch cycle.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tab_addr_ff <= pmtr_pkg::RESET_VECTOR;
			dest_sector_ff <= pmtr_pkg::SECTOR_0;
			dest_addr_ff <= pmtr_pkg::BYTE_RESET;
		end else if (o_cyc_stb && state_ff == pmtr_pkg::PMTR_ST_FETCH && tab_req) begin
			tab_addr_ff <= table_addr(tab_last, tbhp_ff, tblp_ff);
			dest_addr_ff <= i_dest_addr;
			if (i_ext_table_read_op || i_ext_table_read_last_op) begin
				dest_sector_ff <= i_dest_sector;
			end else begin
				dest_sector_ff <= pmtr_pkg::SECTOR_0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Table data delivery and the table-high latch.

	// Low byte goes to the data memory with a one-clock write strobe.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dm_wr_ff <= 1'b0;
			dm_wdata_ff <= pmtr_pkg::BYTE_RESET;
		end else if (phase_ff == pmtr_pkg::PH_T2 && state_ff == pmtr_pkg::PMTR_ST_TABLE) begin
			dm_wr_ff <= 1'b1;
			dm_wdata_ff <= mem_rdata[pmtr_pkg::BYTE_W-1:0];
		end else begin
			dm_wr_ff <= 1'b0;
		end
	end

	assign o_dm_wr = dm_wr_ff;
	assign o_dm_wdata = dm_wdata_ff;
	assign o_dm_sector = dest_sector_ff;
	assign o_dm_addr = dest_addr_ff;

	// The latch takes the high byte of a table word, or an instruction write.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			table_high_latch_ff <= pmtr_pkg::TABLE_HIGH_LATCH_RESET;
		end else if (phase_ff == pmtr_pkg::PH_T2 && state_ff == pmtr_pkg::PMTR_ST_TABLE) begin
			table_high_latch_ff <= mem_rdata[pmtr_pkg::PM_DW-1:pmtr_pkg::BYTE_W] & pmtr_pkg::TABLE_HIGH_LATCH_IMPL_MASK;
		end else if (o_cyc_stb && i_table_high_latch_wr) begin
			table_high_latch_ff <= i_table_high_latch_wdata;
		end
	end

	assign o_table_high_latch = table_high_latch_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Serial programming port.

	// Pin synchronisers; a level counts once the second and third stages agree.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sck_sync_ff <= 3'h0;
			sio_sync_ff <= 3'h0;
			sck_flt_ff <= 1'b0;
			sio_flt_ff <= 1'b0;
		end else begin
			sck_sync_ff <= {sck_sync_ff[1:0], i_prog_serial_clock};
			sio_sync_ff <= {sio_sync_ff[1:0], i_prog_serial_io};
			if (sck_sync_ff[1] == sck_sync_ff[2]) begin
				sck_flt_ff <= sck_sync_ff[2];
			end
			if (sio_sync_ff[1] == sio_sync_ff[2]) begin
				sio_flt_ff <= sio_sync_ff[2];
			end
		end
	end

	assign sck_rise = (sck_sync_ff[1] == sck_sync_ff[2]) && sck_sync_ff[2] && !sck_flt_ff;

	// Frame engine: command, address, then data in (write) or out (read), MSB first.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			icp_cnt_ff <= pmtr_pkg::ICP_CNT_RESET;
			icp_read_ff <= 1'b0;
			icp_addr_ff <= pmtr_pkg::RESET_VECTOR;
			icp_data_ff <= pmtr_pkg::WORD_RESET;
			icp_rd_req_ff <= 1'b0;
			icp_rd_cap_ff <= 1'b0;
			icp_wr_ff <= 1'b0;
			icp_oe_ff <= 1'b0;
		end else if (state_ff != pmtr_pkg::PMTR_ST_PROG) begin
			icp_cnt_ff <= pmtr_pkg::ICP_CNT_RESET;
			icp_oe_ff <= 1'b0;
			icp_rd_req_ff <= 1'b0;
			icp_rd_cap_ff <= 1'b0;
			icp_wr_ff <= 1'b0;
		end else begin
			icp_rd_req_ff <= 1'b0;
			icp_wr_ff <= 1'b0;
			icp_rd_cap_ff <= icp_rd_req_ff;
			if (icp_rd_cap_ff) begin
				icp_data_ff <= mem_rdata;
				icp_oe_ff <= 1'b1;
			end
			if (sck_rise) begin
				if (icp_cnt_ff == pmtr_pkg::ICP_CNT_RESET) begin
					icp_read_ff <= sio_flt_ff;
				end else if (icp_cnt_ff <= pmtr_pkg::ICP_ADDR_LAST) begin
					icp_addr_ff <= {icp_addr_ff[pmtr_pkg::PM_AW-2:0], sio_flt_ff};
					icp_rd_req_ff <= icp_read_ff && (icp_cnt_ff == pmtr_pkg::ICP_ADDR_LAST);
				end else begin
					icp_data_ff <= {icp_data_ff[pmtr_pkg::PM_DW-2:0], sio_flt_ff};
					icp_wr_ff <= !icp_read_ff && (icp_cnt_ff == pmtr_pkg::ICP_FRAME_LAST);
				end
				if (icp_cnt_ff == pmtr_pkg::ICP_FRAME_LAST) begin
					icp_cnt_ff <= pmtr_pkg::ICP_CNT_RESET;
					icp_oe_ff <= 1'b0;
				end else begin
					icp_cnt_ff <= icp_cnt_ff + pmtr_pkg::ICP_CNT_STEP;
				end
			end
		end
	end

	assign o_prog_serial_io = icp_data_ff[pmtr_pkg::PM_DW-1];
	assign o_prog_serial_io_oe = icp_oe_ff;
	assign o_cpu_hold = (state_ff == pmtr_pkg::PMTR_ST_PROG);

endmodule

/* verif/pmtr_reader_monitor.sv */
// Checker of cycle framing, table read timing and PC and latch writes of the reader.
module pmtr_reader_monitor (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic o_cyc_stb,
	input wire logic o_instr_valid,
	input wire logic [11:0] o_pc,
	input wire logic i_jump,
	input wire logic i_pc_low_byte_wr,
	input wire logic [7:0] i_pc_low_byte_wdata,
	input wire logic i_table_read_op,
	input wire logic i_table_read_last_op,
	input wire logic i_ext_table_read_op,
	input wire logic i_ext_table_read_last_op,
	input wire logic [2:0] i_dest_sector,
	input wire logic [7:0] i_dest_addr,
	input wire logic o_dm_wr,
	input wire logic [2:0] o_dm_sector,
	input wire logic [7:0] o_dm_addr,
	input wire logic i_table_high_latch_wr,
	input wire logic [7:0] i_table_high_latch_wdata,
	input wire logic [7:0] o_table_high_latch,
	input wire logic i_prog_en,
	input wire logic o_cpu_hold
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ext_op;
	logic any_op;
	// Groups the table requests; only the extended ones keep the caller's sector.
	assign ext_op = i_ext_table_read_op | i_ext_table_read_last_op;
	assign any_op = ext_op | i_table_read_op | i_table_read_last_op;
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// A request taken at a cycle boundary, then the one-clock low-byte write.
	sequence s_take;
		o_cyc_stb && o_instr_valid && any_op && !i_jump && !i_prog_en && !o_cpu_hold;
	endsequence
	sequence s_write;
		!o_dm_wr ##1 o_dm_wr ##1 !o_dm_wr;
	endsequence
	AST_CYC_PERIOD: assert property (o_cyc_stb |=> !o_cyc_stb [*3] ##1 o_cyc_stb)
		else $error("cycle strobe not every fourth clock");
	AST_RESET_PC: assert property ($rose(i_rst_b) |-> o_pc == 12'h000)
		else $error("pc not at reset vector");
	AST_TBL_WRITE: assert property (s_take |-> ##2 s_write)
		else $error("table low byte write misplaced");
	AST_TBL_GAP: assert property (s_take |-> ##3 !o_instr_valid ##4 o_instr_valid)
		else $error("fetch not paused for one table cycle");
	AST_TBL_PC_HOLD: assert property (s_take |=> $stable(o_pc) [*4])
		else $error("pc moved during table read");
	AST_TBL_DEST: assert property (s_take |-> ##3 o_dm_addr == $past(i_dest_addr, 3)
		&& o_dm_sector == ($past(ext_op, 3) ? $past(i_dest_sector, 3) : 3'h0))
		else $error("table destination wrong");
	AST_PCL_WRITE: assert property (o_cyc_stb && i_pc_low_byte_wr && !i_jump && !i_prog_en
		&& !o_cpu_hold |=> $stable(o_pc[11:8]) && o_pc[7:0] == $past(i_pc_low_byte_wdata))
		else $error("pc low byte write wrong");
	AST_LATCH_WRITE: assert property (o_cyc_stb && i_table_high_latch_wr && !o_cpu_hold
		|=> o_table_high_latch == $past(i_table_high_latch_wdata))
		else $error("latch write lost");
endmodule

/* verif/pmtr_prog_host.sv */
// Serial programmer model that drives the programming clock and shares the data line.
module pmtr_prog_host (
	input wire logic i_clk,
	input wire logic i_dev_io,
	input wire logic i_dev_oe,
	output logic o_clk_pin,
	output logic o_io_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv_ff;
	logic bit_ff;
	// Resolves the data line; a released line shows the inverse of the last bit.
	always_comb o_io_pin = i_dev_oe ? i_dev_io : (drv_ff ? bit_ff : ~bit_ff);
	// Clock stands low and the line is released outside frames.
	initial begin
		o_clk_pin = 1'b0;
		drv_ff = 1'b0;
		bit_ff = 1'b0;
	end
	// Sends command, address and data MSB first and collects the bits shifted back.
	task automatic frame(input logic cmd, input logic [11:0] a, input logic [15:0] d,
		output logic [15:0] q);
		q = 16'h0000;
		for (int i = 0; i < 29; i++) begin
			drv_ff = !(cmd && i > 12);
			bit_ff = 1'({cmd, a, d} >> (28 - i));
			repeat (8) @(posedge i_clk) #1;
			if (i > 12) q = {q[14:0], o_io_pin};
			o_clk_pin = 1'b1;
			repeat (8) @(posedge i_clk) #1;
			o_clk_pin = 1'b0;
		end
		drv_ff = 1'b0;
	endtask
endmodule

/* verif/pmtr_reader_bench.sv */
// Self-checking bench for the program memory reader with a serial programmer model.
module pmtr_reader_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_rst_b, i_jump, i_pc_low_byte_wr, i_tblp_wr, i_tbhp_wr, i_table_high_latch_wr, i_prog_en;
	logic i_table_read_op, i_table_read_last_op, i_ext_table_read_op, i_ext_table_read_last_op;
	logic i_prog_serial_clock, i_prog_serial_io, o_prog_serial_io, o_prog_serial_io_oe;
	logic o_cyc_stb, o_instr_valid, o_dm_wr, o_cpu_hold;
	logic [11:0] i_jump_addr, o_pc;
	logic [7:0] i_pc_low_byte_wdata, i_ptr_wdata, i_dest_addr, i_table_high_latch_wdata, o_pc_low_byte;
	logic [7:0] o_tblp, o_dm_addr, o_dm_wdata, o_table_high_latch;
	logic [15:0] o_instr, rd_word;
	logic [3:0] o_tbhp, ops;
	logic [2:0] i_dest_sector, o_dm_sector;
	int mismatches, checks;
	// One request line per table instruction kind.
	assign {i_ext_table_read_last_op, i_ext_table_read_op, i_table_read_last_op,
		i_table_read_op} = ops;
	pmtr_reader u_pmtr_reader (.*);
	pmtr_prog_host u_host (
		.i_clk(i_clk),
		.i_dev_io(o_prog_serial_io),
		.i_dev_oe(o_prog_serial_io_oe),
		.o_clk_pin(i_prog_serial_clock),
		.o_io_pin(i_prog_serial_io)
	);
	////////////////////////////////////////////////////////////////////////////////
	// Clock of 40 ns period.
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	// Compares one value and counts the outcome.
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Waits for the last clock of an instruction cycle.
	task automatic at_stb;
		for (int n = 0; n < 8 && o_cyc_stb !== 1'b1; n++) @(posedge i_clk) #1;
	endtask
	// Lets the boundary edge take the request, then drops all requests except i_prog_en.
	task automatic go;
		@(posedge i_clk) #1;
		{i_jump, i_pc_low_byte_wr, i_tblp_wr, i_tbhp_wr, i_table_high_latch_wr, ops} = '0;
	endtask
	// Resets for ten clocks; once the store is loaded the first word must come from 000.
	task automatic t_reset(input bit loaded);
		i_rst_b = 1'b0;
		repeat (10) @(posedge i_clk);
		#1 i_rst_b = 1'b1;
		chk("pc", 16'h0000, 16'(o_pc));
		chk("latch", 16'h0000, 16'(o_table_high_latch));
		for (int n = 0; n < 8 && o_instr_valid !== 1'b1; n++) @(posedge i_clk) #1;
		if (loaded) chk("first word", 16'hA55A, o_instr);
		$display("test reset done");
	endtask
	// Loads words serially, reads the top word back, then leaves programming mode.
	task automatic t_program;
		at_stb;
		i_prog_en = 1'b1;
		go;
		for (int n = 0; n < 8 && o_cpu_hold !== 1'b1; n++) @(posedge i_clk) #1;
		chk("hold", 16'h0001, 16'(o_cpu_hold));
		u_host.frame(1'b0, 12'h000, 16'hA55A, rd_word);
		u_host.frame(1'b0, 12'h001, 16'h1234, rd_word);
		u_host.frame(1'b0, 12'h206, 16'hC35A, rd_word);
		u_host.frame(1'b0, 12'hF06, 16'h3C96, rd_word);
		u_host.frame(1'b0, 12'hFFF, 16'h8E71, rd_word);
		u_host.frame(1'b1, 12'hFFF, 16'h0000, rd_word);
		chk("read back", 16'h8E71, rd_word);
		i_prog_en = 1'b0;
		for (int n = 0; n < 8 && o_cpu_hold !== 1'b0; n++) @(posedge i_clk) #1;
		chk("hold", 16'h0000, 16'(o_cpu_hold));
		$display("test program done");
	endtask
	// Runs all four table reads from word 001 and checks bytes, timing and refetch.
	task automatic t_table;
		logic [15:0] w;
		at_stb;
		i_tblp_wr = 1'b1;
		i_ptr_wdata = 8'h06;
		go;
		at_stb;
		i_tbhp_wr = 1'b1;
		i_ptr_wdata = 8'h02;
		go;
		chk("pointer", 16'h0206, {4'h0, o_tbhp, o_tblp});
		for (int k = 0; k < 4; k++) begin
			w = k[0] ? 16'h3C96 : 16'hC35A;
			at_stb;
			i_jump = 1'b1;
			i_jump_addr = 12'h001;
			go;
			at_stb;
			ops = 4'(1 << k);
			i_dest_sector = 3'h5;
			i_dest_addr = 8'(8'h40 + k);
			go;
			@(posedge i_clk) #1;
			chk("early write", 16'h0000, 16'(o_dm_wr));
			@(posedge i_clk) #1;
			chk("write", 16'h0001, 16'(o_dm_wr));
			chk("low byte", 16'(w[7:0]), 16'(o_dm_wdata));
			chk("high", 16'(w[15:8] & pmtr_pkg::TABLE_HIGH_LATCH_IMPL_MASK), 16'(o_table_high_latch));
			chk("sector", k < 2 ? 16'h0000 : 16'h0005, 16'(o_dm_sector));
			chk("dest", 16'(8'h40 + k), 16'(o_dm_addr));
			chk("valid", 16'h0000, 16'(o_instr_valid));
			repeat (4) @(posedge i_clk) #1;
			chk("refetch", 16'h1234, o_instr);
			chk("pc", 16'h0001, 16'(o_pc));
		end
		$display("test table done");
	endtask
	// Writes the latch, then jumps and rewrites the PC low byte within the page.
	task automatic t_writes;
		at_stb;
		i_table_high_latch_wr = 1'b1;
		i_table_high_latch_wdata = 8'hA7;
		go;
		chk("latch", 16'h00A7, 16'(o_table_high_latch));
		at_stb;
		i_jump = 1'b1;
		i_jump_addr = 12'h3F0;
		go;
		at_stb;
		i_pc_low_byte_wr = 1'b1;
		i_pc_low_byte_wdata = 8'h12;
		go;
		chk("pc", 16'h0312, 16'(o_pc));
		chk("pc low", 16'h0012, 16'(o_pc_low_byte));
		$display("test writes done");
	endtask
	// Main sequence.
	initial begin
		{i_rst_b, i_jump, i_pc_low_byte_wr, i_tblp_wr, i_tbhp_wr, i_table_high_latch_wr, i_prog_en, ops} = '0;
		{i_jump_addr, i_pc_low_byte_wdata, i_ptr_wdata, i_dest_addr, i_table_high_latch_wdata} = '0;
		i_dest_sector = 3'h0;
		mismatches = 0;
		checks = 0;
		t_reset(1'b0);
		t_program;
		t_reset(1'b1);
		t_table;
		t_writes;
		stop_test;
	end
	// Watchdog well beyond the expected run of some 2900 clocks.
	initial begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		stop_test;
	end
endmodule
bind pmtr_reader pmtr_reader_monitor u_pmtr_reader_monitor (.*);
